// ===== verilog/cpu_ctrl_regs.sv
// cpu control registers: program counter, status word and stack pointer,
// with address-map decode and byte-wide vector, stack and return sequencing.
// assumes an avalon-mm master on core_clk and a same-clock byte memory port.
//
// Contract
// [R1] decode the whole 64 KB address space into its regions
// [R2] memory size register resets to CFH, software then writes its own value
// [R3] 0000H-003FH is the 64-byte start-address table
// [R4] table entry: low byte at even address, high byte at next odd address
// [R5] reset, interrupt or break trap branch via table entry; break uses 003EH
// [R6] table call fetches its entry from 0040H-007FH
// [R7] fixed-area call only targets 0800H-0FFFH
// [R8] FEE0H-FEFFH holds four banks of eight 8-bit registers
// [R9] software never executes from the bank area
// [R10] peripherals live at FF00H-FFFFH; software avoids unassigned addresses
// [R11] program counter advances by instruction length or loads branch target
// [R12] reset loads program counter from 0000H and 0001H
// [R13] status word pushed on interrupt and push, restored by returns and pop
// [R14] reset sets status word to 02H
// [R15] master enable gates maskable requests; cleared by mask-all or accept
// [R16] zero flag set for zero result, cleared otherwise
// [R17] 2-bit bank select field written by bank switch
// [R18] half-carry set on carry out of or borrow at bit 3
// [R19] low-priority requests refused while service priority flag is 0
// [R20] carry holds add/sub overflow, rotate shift-out, bit accumulator
// [R21] stack pointer pre-decrements on write, post-increments on read
// [R22] stack pointer undefined after reset; software sets it first

`timescale 1ns/1ps
`default_nettype none

module cpu_ctrl_regs (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic [7:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  output logic      [15:0]               mem_addr,
  output logic                           mem_read,
  output logic                           mem_write,
  output logic      [7:0]                mem_wdata,
  input  wire logic [7:0]                mem_rdata,
  input  wire logic                      mem_ready,
  output cpu_ctrl_pkg::region_t          mem_region,
  output logic      [1:0]                bank_sel
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cpu_ctrl_pkg::ctrl_state_t s_q;
  cpu_ctrl_pkg::ctrl_state_t s_d;

  logic        req;
  logic        commit_wr;
  logic        exec;
  logic        accept_go;
  logic        alu_go;
  logic [15:0] cand;
  logic [3:0]  src;
  logic [15:0] arg;
  logic [3:0]  op;
  logic [2:0]  sub;
  logic [8:0]  sum;
  logic [7:0]  alu_res;

  function automatic logic [3:0] lowest_set(input logic [15:0] v);
    lowest_set = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) lowest_set = 4'(i);
    end
  endfunction

  assign req       = avs_read | avs_write;
  assign commit_wr = avs_write && !s_q.wait_r;
  assign exec      = commit_wr && avs_address == cpu_ctrl_pkg::REG_CMD;
  assign op        = avs_writedata[cpu_ctrl_pkg::CMD_OP_LSB +: 4];
  assign sub       = avs_writedata[cpu_ctrl_pkg::CMD_SUB_LSB +: 3];
  assign arg       = avs_writedata[cpu_ctrl_pkg::CMD_ARG_LSB +: 16];
  // only masked-in sources; low-priority ones need the service flag set
  assign cand      = s_q.pend & ~s_q.mask
                     & (s_q.processor_status_word[cpu_ctrl_pkg::PSW_ISP] ? 16'hFFFF : ~s_q.lowpri); // see [R19]
  assign src       = lowest_set(cand);
  assign accept_go = exec && op == cpu_ctrl_pkg::OP_INT_ACCEPT
                     && s_q.processor_status_word[cpu_ctrl_pkg::PSW_IE] && cand != 16'h0000; // see [R15]
  assign alu_go    = exec && op == cpu_ctrl_pkg::OP_ALU;

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.wait_r;
  assign mem_addr        = s_q.maddr;
  assign mem_read        = s_q.mrd;
  assign mem_write       = s_q.mwr;
  assign mem_wdata       = s_q.mwd;
  assign mem_region      = s_q.mregion;
  assign bank_sel        = {s_q.processor_status_word[cpu_ctrl_pkg::PSW_BANK_SELECT_HIGH], s_q.processor_status_word[cpu_ctrl_pkg::PSW_BANK_SELECT_LOW]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    sum     = 9'h000;
    alu_res = 8'h00;

    // avalon slave: one wait cycle, then commit; writes stall while busy
    if (req && s_q.wait_r) begin
      if (!(avs_write && s_q.st != cpu_ctrl_pkg::S_IDLE)) begin
        s_d.wait_r = 1'b0;
      end
      case (avs_address)
        cpu_ctrl_pkg::REG_PC:      s_d.rdata = {16'h0000, s_q.pc};
        cpu_ctrl_pkg::REG_PSW:     s_d.rdata = {24'h000000, s_q.processor_status_word};
        cpu_ctrl_pkg::REG_SP:      s_d.rdata = {16'h0000, s_q.sp};
        cpu_ctrl_pkg::REG_MEMSIZE: s_d.rdata = {24'h000000, s_q.memsize};
        cpu_ctrl_pkg::REG_STATUS:  s_d.rdata = {29'h00000000, s_q.bank_exec, s_q.refused,
                                               s_q.st != cpu_ctrl_pkg::S_IDLE};
        cpu_ctrl_pkg::REG_RESULT:  s_d.rdata = {24'h000000, s_q.result};
        cpu_ctrl_pkg::REG_PEND:    s_d.rdata = {16'h0000, s_q.pend};
        cpu_ctrl_pkg::REG_MASK:    s_d.rdata = {16'h0000, s_q.mask};
        cpu_ctrl_pkg::REG_LOWPRI:  s_d.rdata = {16'h0000, s_q.lowpri};
        cpu_ctrl_pkg::REG_DECODE:  s_d.rdata = {13'h0000, cpu_ctrl_pkg::region_of(s_q.decode_addr),
                                               s_q.decode_addr}; // see [R1]
        default:                   s_d.rdata = 32'h0000_0000;
      endcase
    end else if (req) begin
      s_d.wait_r = 1'b1;
    end

    if (commit_wr) begin
      case (avs_address)
        cpu_ctrl_pkg::REG_PC: begin
          s_d.pc = avs_writedata[15:0];
          if (cpu_ctrl_pkg::region_of(avs_writedata[15:0]) == cpu_ctrl_pkg::RG_BANKS) begin
            s_d.bank_exec = 1'b1; // see [R9]
          end
        end
        cpu_ctrl_pkg::REG_PSW:     s_d.processor_status_word = avs_writedata[7:0];
        cpu_ctrl_pkg::REG_SP:      s_d.sp = avs_writedata[15:0]; // see [R22]
        cpu_ctrl_pkg::REG_MEMSIZE: s_d.memsize = avs_writedata[7:0]; // see [R2]
        cpu_ctrl_pkg::REG_STATUS: begin
          if (avs_writedata[cpu_ctrl_pkg::ST_REFUSED]) s_d.refused = 1'b0;
          if (avs_writedata[cpu_ctrl_pkg::ST_BANK_EXEC]) s_d.bank_exec = 1'b0;
        end
        cpu_ctrl_pkg::REG_PEND:    s_d.pend = s_q.pend | avs_writedata[15:0];
        cpu_ctrl_pkg::REG_MASK:    s_d.mask = avs_writedata[15:0];
        cpu_ctrl_pkg::REG_LOWPRI:  s_d.lowpri = avs_writedata[15:0];
        cpu_ctrl_pkg::REG_DECODE:  s_d.decode_addr = avs_writedata[15:0];
        default: ;
      endcase
    end

    // command execution; only reached in idle since busy stalls writes
    if (exec) begin
      case (op)
        cpu_ctrl_pkg::OP_ADVANCE: s_d.pc = s_q.pc + {13'h0000, arg[2:0]}; // see [R11]
        cpu_ctrl_pkg::OP_BRANCH: begin
          s_d.pc = arg; // see [R11]
          if (cpu_ctrl_pkg::region_of(arg) == cpu_ctrl_pkg::RG_BANKS) s_d.bank_exec = 1'b1;
        end
        cpu_ctrl_pkg::OP_TABLE_CALL: begin
          s_d.vec     = cpu_ctrl_pkg::TABLE_CALL_BASE | {10'h000, arg[4:0], 1'b0}; // see [R6]
          s_d.fetch   = 1'b1;
          s_d.stk_buf = {s_q.pc, 8'h00};
          s_d.stk_n   = 2'h2;
        end
        cpu_ctrl_pkg::OP_FIXED_CALL: begin
          s_d.pc_new  = cpu_ctrl_pkg::FIXED_AREA_CALL_BASE | {5'h00, arg[10:0]}; // see [R7]
          s_d.fetch   = 1'b0;
          s_d.stk_buf = {s_q.pc, 8'h00};
          s_d.stk_n   = 2'h2;
        end
        cpu_ctrl_pkg::OP_BREAK_TRAP: begin
          s_d.vec     = cpu_ctrl_pkg::VEC_BREAK; // see [R5]
          s_d.fetch   = 1'b1;
          s_d.stk_buf = {s_q.processor_status_word, s_q.pc}; // see [R13]
          s_d.stk_n   = 2'h3;
          s_d.processor_status_word[cpu_ctrl_pkg::PSW_IE] = 1'b0;
        end
        cpu_ctrl_pkg::OP_INT_ACCEPT: begin
          if (accept_go) begin
            s_d.vec     = cpu_ctrl_pkg::VEC_IRQ_BASE + {11'h000, src, 1'b0}; // see [R5]
            s_d.fetch   = 1'b1;
            s_d.stk_buf = {s_q.processor_status_word, s_q.pc}; // see [R13]
            s_d.stk_n   = 2'h3;
            s_d.pend[src] = 1'b0;
            s_d.processor_status_word[cpu_ctrl_pkg::PSW_IE]  = 1'b0; // see [R15]
            s_d.processor_status_word[cpu_ctrl_pkg::PSW_ISP] = s_q.lowpri[src];
          end else begin
            s_d.refused = 1'b1;
          end
        end
        cpu_ctrl_pkg::OP_RETURN: begin
          s_d.stk_n    = 2'h3; // see [R13]
          s_d.full_pop = 1'b1;
        end
        cpu_ctrl_pkg::OP_PUSH_PSW: begin
          s_d.pc_new  = s_q.pc;
          s_d.fetch   = 1'b0;
          s_d.stk_buf = {s_q.processor_status_word, 16'h0000}; // see [R13]
          s_d.stk_n   = 2'h1;
        end
        cpu_ctrl_pkg::OP_POP_PSW: begin
          s_d.stk_n    = 2'h1; // see [R13]
          s_d.full_pop = 1'b0;
        end
        cpu_ctrl_pkg::OP_MASK_ALL:   s_d.processor_status_word[cpu_ctrl_pkg::PSW_IE] = 1'b0; // see [R15]
        cpu_ctrl_pkg::OP_UNMASK_ALL: s_d.processor_status_word[cpu_ctrl_pkg::PSW_IE] = 1'b1; // see [R15]
        cpu_ctrl_pkg::OP_BANK_SWITCH: begin
          s_d.processor_status_word[cpu_ctrl_pkg::PSW_BANK_SELECT_HIGH] = arg[1]; // see [R17]
          s_d.processor_status_word[cpu_ctrl_pkg::PSW_BANK_SELECT_LOW] = arg[0];
        end
        cpu_ctrl_pkg::OP_ALU: begin
          case (sub)
            cpu_ctrl_pkg::ALU_ADD: sum = {1'b0, arg[15:8]} + {1'b0, arg[7:0]};
            cpu_ctrl_pkg::ALU_SUB: sum = {1'b0, arg[15:8]} - {1'b0, arg[7:0]};
            default:               sum = 9'h000;
          endcase
          case (sub)
            cpu_ctrl_pkg::ALU_ADD, cpu_ctrl_pkg::ALU_SUB: begin
              alu_res = sum[7:0];
              s_d.processor_status_word[cpu_ctrl_pkg::PSW_CY] = sum[8]; // see [R20]
              // bit 4 of a^b^r is the carry into, or borrow from, bit 4
              s_d.processor_status_word[cpu_ctrl_pkg::PSW_AC] = arg[12] ^ arg[4] ^ sum[4]; // see [R18]
              s_d.processor_status_word[cpu_ctrl_pkg::PSW_Z]  = sum[7:0] == 8'h00; // see [R16]
            end
            cpu_ctrl_pkg::ALU_ROL: begin
              alu_res = {arg[14:8], arg[15]};
              s_d.processor_status_word[cpu_ctrl_pkg::PSW_CY] = arg[15]; // see [R20]
            end
            cpu_ctrl_pkg::ALU_ROR: begin
              alu_res = {arg[8], arg[15:9]};
              s_d.processor_status_word[cpu_ctrl_pkg::PSW_CY] = arg[8]; // see [R20]
            end
            cpu_ctrl_pkg::ALU_BIT_AND: begin
              alu_res = s_q.result;
              s_d.processor_status_word[cpu_ctrl_pkg::PSW_CY] = s_q.processor_status_word[cpu_ctrl_pkg::PSW_CY] & arg[0];
            end
            cpu_ctrl_pkg::ALU_BIT_OR: begin
              alu_res = s_q.result;
              s_d.processor_status_word[cpu_ctrl_pkg::PSW_CY] = s_q.processor_status_word[cpu_ctrl_pkg::PSW_CY] | arg[0];
            end
            default: alu_res = s_q.result;
          endcase
          s_d.result = alu_res;
        end
        default: ;
      endcase
      // kick off the stack sequence chosen above
      if (s_d.stk_n != 2'h0 && op != cpu_ctrl_pkg::OP_RETURN && op != cpu_ctrl_pkg::OP_POP_PSW) begin
        s_d.st    = cpu_ctrl_pkg::S_PUSH;
        s_d.sp    = s_q.sp - 16'h0001; // see [R21]
        s_d.maddr = s_q.sp - 16'h0001;
        s_d.mwr   = 1'b1;
        s_d.mwd   = s_d.stk_buf[23:16];
      end else if (s_d.stk_n != 2'h0) begin
        s_d.st      = cpu_ctrl_pkg::S_POP;
        s_d.maddr   = s_q.sp;
        s_d.mrd     = 1'b1;
        s_d.stk_buf = 24'h000000;
      end
    end

    // byte sequencer on the memory port
    case (s_q.st)
      cpu_ctrl_pkg::S_IDLE: ;
      cpu_ctrl_pkg::S_VEC_LO: begin
        if (mem_ready) begin
          s_d.vec_lo = mem_rdata; // see [R4]
          s_d.maddr  = s_q.maddr + 16'h0001;
          s_d.st     = cpu_ctrl_pkg::S_VEC_HI;
        end
      end
      cpu_ctrl_pkg::S_VEC_HI: begin
        if (mem_ready) begin
          s_d.pc  = {mem_rdata, s_q.vec_lo}; // see [R4] see [R12]
          s_d.mrd = 1'b0;
          s_d.st  = cpu_ctrl_pkg::S_IDLE;
        end
      end
      cpu_ctrl_pkg::S_PUSH: begin
        if (mem_ready) begin
          s_d.stk_buf = {s_q.stk_buf[15:0], 8'h00};
          s_d.stk_n   = s_q.stk_n - 2'h1;
          if (s_q.stk_n > 2'h1) begin
            s_d.sp    = s_q.sp - 16'h0001; // see [R21]
            s_d.maddr = s_q.sp - 16'h0001;
            s_d.mwd   = s_q.stk_buf[15:8];
          end else begin
            s_d.mwr = 1'b0;
            if (s_q.fetch) begin
              s_d.maddr = s_q.vec;
              s_d.mrd   = 1'b1;
              s_d.st    = cpu_ctrl_pkg::S_VEC_LO;
            end else begin
              s_d.pc = s_q.pc_new;
              s_d.st = cpu_ctrl_pkg::S_IDLE;
            end
          end
        end
      end
      cpu_ctrl_pkg::S_POP: begin
        if (mem_ready) begin
          s_d.stk_buf = {mem_rdata, s_q.stk_buf[23:8]};
          s_d.stk_n   = s_q.stk_n - 2'h1;
          s_d.sp      = s_q.sp + 16'h0001; // see [R21]
          s_d.maddr   = s_q.sp + 16'h0001;
          if (s_q.stk_n == 2'h1) begin
            s_d.mrd = 1'b0;
            s_d.processor_status_word = mem_rdata; // see [R13]
            if (s_q.full_pop) s_d.pc = s_q.stk_buf[23:8];
            s_d.st = cpu_ctrl_pkg::S_IDLE;
          end
        end
      end
      default: s_d.st = cpu_ctrl_pkg::S_IDLE;
    endcase

    s_d.mregion = cpu_ctrl_pkg::region_of(s_d.maddr); // see [R1] see [R8] see [R10] see [R3]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= cpu_ctrl_pkg::STATE_RESET; // see [R14] see [R2] see [R12]
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_psw_reset_val: assert property ($past(rst) |-> s_q.processor_status_word == 8'h02) // see [R14]
    else $error("status word not 02H after reset");
  chk_reset_vector: assert property ($past(rst) |-> mem_read && mem_addr == 16'h0000) // see [R12]
    else $error("reset vector fetch not at 0000H");
  chk_vec_byte_order: assert property (s_q.st == cpu_ctrl_pkg::S_VEC_LO && mem_ready
    |=> mem_addr == $past(mem_addr) + 16'h0001 ##0 s_q.vec_lo == $past(mem_rdata)) // see [R4]
    else $error("vector high byte not fetched from next address");
  chk_sp_predec: assert property ($rose(mem_write) |-> mem_addr == s_q.sp
    && s_q.sp == $past(s_q.sp) - 16'h0001) // see [R21]
    else $error("stack write without pre-decrement");
  chk_sp_postinc: assert property (s_q.st == cpu_ctrl_pkg::S_POP && mem_ready
    |=> s_q.sp == $past(s_q.sp) + 16'h0001) // see [R21]
    else $error("stack read without post-increment");
  chk_ie_gate: assert property (accept_go |=> !s_q.processor_status_word[cpu_ctrl_pkg::PSW_IE]
    && $past(s_q.processor_status_word[cpu_ctrl_pkg::PSW_IE])) // see [R15]
    else $error("interrupt accepted while masked or enable not cleared");
  chk_low_prio_block: assert property (accept_go && !s_q.processor_status_word[cpu_ctrl_pkg::PSW_ISP]
    |-> !s_q.lowpri[src]) // see [R19]
    else $error("low-priority request accepted with service flag clear");
  chk_zero_flag: assert property (alu_go && sub <= 3'h1
    |=> s_q.processor_status_word[cpu_ctrl_pkg::PSW_Z] == (s_q.result == 8'h00)) // see [R16]
    else $error("zero flag does not match result");
  chk_fixed_target: assert property (exec && op == cpu_ctrl_pkg::OP_FIXED_CALL
    |=> s_q.pc_new >= 16'h0800 && s_q.pc_new <= 16'h0FFF) // see [R7]
    else $error("fixed-area call target outside its region");
  chk_wait_answer: assert property (req && s_q.wait_r && s_q.st == cpu_ctrl_pkg::S_IDLE
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("register access not answered in one cycle");

  cov_reset_done: cover property ($past(rst) ##[1:20] s_q.st == cpu_ctrl_pkg::S_IDLE);
  cov_int_accept: cover property (accept_go);
  cov_table_call: cover property (exec && op == cpu_ctrl_pkg::OP_TABLE_CALL);
  cov_alu_zero:   cover property (alu_go ##1 s_q.processor_status_word[cpu_ctrl_pkg::PSW_Z]);

endmodule

`default_nettype wire

// ===== shared/cpu_ctrl_pkg.sv
// package for the cpu control-register block: register offsets, field
// positions, reset values, memory map limits, commands and state types.
// assumes a 16-bit flat byte address map and an 8-bit memory data path.

package cpu_ctrl_pkg;

  // ----------------------------------------------------------------
  // avalon register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD     = 8'h00;
  localparam logic [7:0] REG_PC      = 8'h04;
  localparam logic [7:0] REG_PSW     = 8'h08;
  localparam logic [7:0] REG_SP      = 8'h0C;
  localparam logic [7:0] REG_MEMSIZE = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] REG_RESULT  = 8'h18;
  localparam logic [7:0] REG_PEND    = 8'h1C;
  localparam logic [7:0] REG_MASK    = 8'h20;
  localparam logic [7:0] REG_LOWPRI  = 8'h24;
  localparam logic [7:0] REG_DECODE  = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PSW_IE   = 7;
  localparam int PSW_Z    = 6;
  localparam int PSW_BANK_SELECT_HIGH = 5;
  localparam int PSW_AC   = 4;
  localparam int PSW_BANK_SELECT_LOW = 3;
  localparam int PSW_ISP  = 1;
  localparam int PSW_CY   = 0;
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_SUB_LSB = 4;
  localparam int CMD_ARG_LSB = 8;
  localparam int ST_BUSY      = 0;
  localparam int ST_REFUSED   = 1;
  localparam int ST_BANK_EXEC = 2;

  // ----------------------------------------------------------------
  // reset values and memory map
  // ----------------------------------------------------------------
  localparam logic [7:0]  PSW_RESET     = 8'h02;
  localparam logic [7:0]  MEMSIZE_RESET = 8'hCF;
  localparam logic [15:0] IRQ_RESET     = 16'hFFFF;
  localparam logic [15:0] VEC_RESET     = 16'h0000;
  localparam logic [15:0] VEC_TABLE_END = 16'h003F;
  localparam logic [15:0] VEC_IRQ_BASE  = 16'h0004;
  localparam logic [15:0] VEC_BREAK     = 16'h003E;
  localparam logic [15:0] TABLE_CALL_BASE    = 16'h0040;
  localparam logic [15:0] TABLE_CALL_END     = 16'h007F;
  localparam logic [15:0] FIXED_AREA_CALL_BASE    = 16'h0800;
  localparam logic [15:0] FIXED_AREA_CALL_END     = 16'h0FFF;
  localparam logic [15:0] BANK_BASE     = 16'hFEE0;
  localparam logic [15:0] BANK_END      = 16'hFEFF;
  localparam logic [15:0] PERIPH_BASE   = 16'hFF00;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ADVANCE = 4'h1, OP_BRANCH = 4'h2, OP_TABLE_CALL = 4'h3,
    OP_FIXED_CALL = 4'h4, OP_BREAK_TRAP = 4'h5, OP_INT_ACCEPT = 4'h6,
    OP_RETURN = 4'h7, OP_PUSH_PSW = 4'h8, OP_POP_PSW = 4'h9, OP_MASK_ALL = 4'hA,
    OP_UNMASK_ALL = 4'hB, OP_BANK_SWITCH = 4'hC, OP_ALU = 4'hD
  } op_t;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_SUB = 3'h1, ALU_ROL = 3'h2, ALU_ROR = 3'h3,
    ALU_BIT_AND = 3'h4, ALU_BIT_OR = 3'h5
  } alu_mode_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_VEC_LO = 3'h1, S_VEC_HI = 3'h2, S_PUSH = 3'h3, S_POP = 3'h4
  } state_t;

  typedef enum logic [2:0] {
    RG_VECTOR = 3'h0, RG_CALL_TABLE = 3'h1, RG_FIXED_CALL = 3'h2, RG_PROGRAM = 3'h3,
    RG_DATA = 3'h4, RG_BANKS = 3'h5, RG_PERIPH = 3'h6
  } region_t;

  typedef struct packed {
    state_t      st;
    logic [15:0] pc;
    logic [7:0]  processor_status_word;
    logic [15:0] sp;
    logic [7:0]  memsize;
    logic [7:0]  result;
    logic [15:0] pend;
    logic [15:0] mask;
    logic [15:0] lowpri;
    logic [15:0] decode_addr;
    logic        refused;
    logic        bank_exec;
    logic        wait_r;
    logic [31:0] rdata;
    logic [15:0] maddr;
    logic        mrd;
    logic        mwr;
    logic [7:0]  mwd;
    region_t     mregion;
    logic [23:0] stk_buf;
    logic [1:0]  stk_n;
    logic        full_pop;
    logic        fetch;
    logic [15:0] vec;
    logic [7:0]  vec_lo;
    logic [15:0] pc_new;
  } ctrl_state_t;

  // after reset the block is already fetching the reset vector low byte
  localparam ctrl_state_t STATE_RESET = '{
    st: S_VEC_LO, pc: 16'h0000, processor_status_word: PSW_RESET, sp: 16'h0000,
    memsize: MEMSIZE_RESET, result: 8'h00, pend: 16'h0000, mask: IRQ_RESET,
    lowpri: IRQ_RESET, decode_addr: 16'h0000, refused: 1'b0, bank_exec: 1'b0,
    wait_r: 1'b1, rdata: 32'h0000_0000, maddr: VEC_RESET, mrd: 1'b1, mwr: 1'b0,
    mwd: 8'h00, mregion: RG_VECTOR, stk_buf: 24'h000000, stk_n: 2'h0,
    full_pop: 1'b0, fetch: 1'b0, vec: 16'h0000, vec_lo: 8'h00, pc_new: 16'h0000};

  function automatic region_t region_of(input logic [15:0] a);
    if (a <= VEC_TABLE_END) region_of = RG_VECTOR;
    else if (a <= TABLE_CALL_END) region_of = RG_CALL_TABLE;
    else if (a >= FIXED_AREA_CALL_BASE && a <= FIXED_AREA_CALL_END) region_of = RG_FIXED_CALL;
    else if (a >= PERIPH_BASE) region_of = RG_PERIPH;
    else if (a >= BANK_BASE && a <= BANK_END) region_of = RG_BANKS;
    else if (a[15]) region_of = RG_DATA;
    else region_of = RG_PROGRAM;
  endfunction

endpackage

// ===== verification/mem_model.sv
// partner: byte memory behind the control block, answering after a random delay.
// assumes the block holds strobe, address and data until it sees mem_ready high.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_read,
  input  wire logic        mem_write,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  output logic             mem_ready
);
  logic [7:0] mem [0:65535];
  int         dly = 0;
  initial begin
    for (int a = 0; a < 65536; a++) mem[a] = 8'(a ^ (a >> 8) ^ 8'h5A);
    mem_ready = 1'b0;
    mem_rdata = 8'h00;
  end
  // read data is inverted once taken, so a late sample never sees a stale match
  always @(posedge core_clk) begin
    if (mem_ready) begin
      if (mem_write) mem[mem_addr] <= mem_wdata;
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if ((mem_read || mem_write) && dly == 0) begin
      mem_ready <= 1'b1;
      mem_rdata <= mem[mem_addr];
      dly <= $urandom_range(3);
    end else if (mem_read || mem_write) begin
      dly <= dly - 1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/cpu_memory_map_control_regs_tb.sv
// self-checking bench: avalon tasks drive commands, a bench model predicts results.
// assumes mem_model answers every memory strobe within a few cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module cpu_memory_map_control_regs_tb;
  logic                  core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]            avs_address = 8'h00, mem_wdata, mem_rdata;
  logic [31:0]           avs_writedata = 32'h0, avs_readdata, q;
  logic                  avs_waitrequest, mem_read, mem_write, mem_ready;
  logic [15:0]           mem_addr, pc, sp;
  logic [1:0]            bank_sel;
  cpu_ctrl_pkg::region_t mem_region;
  logic [15:0]           ads [7] = '{16'h003F, 16'h0040, 16'h0FFF, 16'h7FFF,
                                     16'hFEDF, 16'hFEE0, 16'hFF00};
  int                    err_total = 0, n_compared = 0, a, b, r, e;
  always #10 core_clk = ~core_clk;
  cpu_ctrl_regs dut (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .mem_addr, .mem_read, .mem_write, .mem_wdata,
    .mem_rdata, .mem_ready, .mem_region, .bank_sel);
  mem_model m (.core_clk, .mem_addr, .mem_read, .mem_write, .mem_wdata, .mem_rdata,
    .mem_ready);
  task automatic report_and_stop();
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one edge is left idle after each release so no strobe is driven twice per step
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    for (n = 0; n < 300; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 300) begin
      err_total++;
      report_and_stop();
    end
    @(posedge core_clk);
  endtask
  task automatic ck(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    `CHK($sformatf("reg_%h", ad), e, q)
  endtask
  task automatic cmd(input logic [3:0] op, input logic [2:0] sub, input logic [15:0] arg);
    bus(1'b1, cpu_ctrl_pkg::REG_CMD, {8'h00, arg, 1'b0, sub, op});
    q = 32'h1;
    for (int i = 0; i < 40 && q[0] !== 1'b0; i++) bus(1'b0, cpu_ctrl_pkg::REG_STATUS, 32'h0);
    if (q[0] !== 1'b0) begin
      err_total++;
      report_and_stop();
    end
  endtask
  initial begin
    q = $urandom(22);
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    ck(cpu_ctrl_pkg::REG_PSW, 32'h02);
    ck(cpu_ctrl_pkg::REG_MEMSIZE, 32'hCF);
    cmd(4'h0, 3'h0, 16'h0);
    ck(cpu_ctrl_pkg::REG_PC, {m.mem[1], m.mem[0]});
    bus(1'b1, cpu_ctrl_pkg::REG_MEMSIZE, 32'h42);
    ck(cpu_ctrl_pkg::REG_MEMSIZE, 32'h42);
    sp = 16'hFEE0;
    bus(1'b1, cpu_ctrl_pkg::REG_SP, sp);
    pc = $urandom & 16'h7FFF;
    a = $urandom_range(7);
    cmd(4'h2, 3'h0, pc);
    cmd(4'h1, 3'h0, 16'(a));
    pc = pc + 16'(a);
    ck(cpu_ctrl_pkg::REG_PC, pc);
    cmd(4'h8, 3'h0, 16'h0);
    `CHK("pushed", 8'h02, m.mem[sp - 1])
    ck(cpu_ctrl_pkg::REG_SP, sp - 1);
    cmd(4'h9, 3'h0, 16'h0);
    ck(cpu_ctrl_pkg::REG_SP, sp);
    a = $urandom_range(31);
    cmd(4'h3, 3'h0, 16'(a));
    ck(cpu_ctrl_pkg::REG_PC, {m.mem[65 + 2 * a], m.mem[64 + 2 * a]});
    `CHK("ret_addr", pc, {m.mem[sp - 1], m.mem[sp - 2]})
    sp = sp - 2;
    pc = {m.mem[65 + 2 * a], m.mem[64 + 2 * a]};
    cmd(4'h5, 3'h0, 16'h0);
    ck(cpu_ctrl_pkg::REG_PC, {m.mem[16'h3F], m.mem[16'h3E]});
    cmd(4'h7, 3'h0, 16'h0);
    ck(cpu_ctrl_pkg::REG_PC, pc);
    ck(cpu_ctrl_pkg::REG_SP, sp);
    bus(1'b1, cpu_ctrl_pkg::REG_MASK, 32'h0);
    bus(1'b1, cpu_ctrl_pkg::REG_PSW, 32'h80);
    bus(1'b1, cpu_ctrl_pkg::REG_PEND, 32'h1);
    cmd(4'h6, 3'h0, 16'h0);
    ck(cpu_ctrl_pkg::REG_STATUS, 32'h2);
    bus(1'b1, cpu_ctrl_pkg::REG_STATUS, 32'h6);
    bus(1'b1, cpu_ctrl_pkg::REG_LOWPRI, 32'h0);
    cmd(4'h6, 3'h0, 16'h0);
    ck(cpu_ctrl_pkg::REG_PC, {m.mem[5], m.mem[4]});
    a = $urandom_range(2047);
    cmd(4'h4, 3'h0, 16'(a));
    ck(cpu_ctrl_pkg::REG_PC, 32'h800 + a);
    `CHK("ret_addr", {m.mem[5], m.mem[4]}, {m.mem[16'hFEDA], m.mem[16'hFED9]})
    ck(cpu_ctrl_pkg::REG_SP, sp - 5);
    cmd(4'hB, 3'h0, 16'h0);
    ck(cpu_ctrl_pkg::REG_PSW, 32'h80);
    cmd(4'hA, 3'h0, 16'h0);
    bus(1'b1, cpu_ctrl_pkg::REG_PEND, 32'h1);
    cmd(4'h6, 3'h0, 16'h0);
    ck(cpu_ctrl_pkg::REG_STATUS, 32'h2);
    for (int k = 0; k < 4; k++) begin
      cmd(4'hC, 3'h0, 16'(k));
      `CHK("bank", 2'(k), bank_sel)
    end
    for (int k = 0; k < 12; k++) begin
      r = k % 2;
      a = $urandom_range(255);
      b = (k % 4 < 2) ? ((r ? a : 256 - a) & 255) : $urandom_range(255);
      e = r ? a - b : a + b;
      cmd(4'hD, 3'(r), 16'(a * 256 + b));
      ck(cpu_ctrl_pkg::REG_RESULT, e & 255);
      ck(cpu_ctrl_pkg::REG_PSW, 8'h28 | ((e & 255) == 0) << 6 | (e < 0 || e > 255) |
        (r ? a % 16 < b % 16 : a % 16 + b % 16 > 15) << 4);
    end
    // rotate left, rotate right, then carry as bit accumulator (and, or)
    for (int k = 2; k < 6; k++) begin
      a = $urandom_range(255);
      b = k < 4 ? (k == 2 ? a / 128 : a % 2) : (k == 4 ? b & a % 2 : b | a % 2);
      cmd(4'hD, 3'(k), 16'(k < 4 ? a * 256 : a));
      if (k < 4) ck(cpu_ctrl_pkg::REG_RESULT, k == 2 ? (a * 2 + a / 128) & 255 : a / 2 + a % 2 * 128);
      bus(1'b0, cpu_ctrl_pkg::REG_PSW, 32'h0);
      `CHK("carry", b, q[0])
    end
    for (int k = 0; k < 7; k++) begin
      bus(1'b1, cpu_ctrl_pkg::REG_DECODE, ads[k]);
      ck(cpu_ctrl_pkg::REG_DECODE, {k[2:0], ads[k]});
    end
    ck(8'h3C, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
